// [rtl/aprr_map.svh]
// Register indexes, field positions, masks and reset values
`ifndef APRR_MAP_SVH
`define APRR_MAP_SVH

`define APRR_SEL_RESULT 3'h0
`define APRR_SEL_FLAGS 3'h1
`define APRR_SEL_CONFIG 3'h2
`define APRR_SEL_LOW 3'h3
`define APRR_SEL_HIGH 3'h4
`define APRR_SEL_HYST 3'h5
`define APRR_SEL_MIN 3'h6
`define APRR_SEL_MAX 3'h7

`define APRR_PTR_RST 8'h00
`define APRR_CFG_RST 8'h00
`define APRR_FLAGS_RST 2'h0
`define APRR_LOW_RST 16'h0000
`define APRR_HIGH_RST 16'h0fff
`define APRR_HYST_RST 16'h0000
`define APRR_MIN_RST 16'h0fff
`define APRR_MAX_RST 16'h0000
`define APRR_SAMPLE_RST 10'h000

`define APRR_BIT_OVER 1
`define APRR_BIT_UNDER 0
`define APRR_CFG_HOLD 4
`define APRR_CFG_FLAG_EN 3
`define APRR_CFG_CYC_HI 7
`define APRR_CFG_CYC_LO 5
`define APRR_CFG_WMASK 8'hfd
`define APRR_WORD_WMASK 16'h0ffc
`define APRR_AUTO_OFF 3'h0

`endif

// [rtl/aprr_pkg.sv]
// Types shared by the pointer, result and alert register bank
package aprr_pkg;

    // One byte written by the serial engine
    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } aprr_wbyte_s;

    // One finished conversion from the converter core
    typedef struct packed {
        logic valid;
        logic [9:0] value;
    } aprr_sample_s;

    // Byte position inside a transaction, one-hot
    typedef enum logic [3:0] {
        AP_IDLE = 4'b0001,
        AP_PTR = 4'b0010,
        AP_HI = 4'b0100,
        AP_LO = 4'b1000
    } aprr_phase_e;

endpackage

// [rtl/aprr_regs.sv]
// Pointer, conversion result and alert status register bank
// Interface
// A serial engine on the same clock hands over whole bytes. A write
// transaction opens with i_txn_start and i_txn_write high; its first byte
// is the pointer, later bytes are data. A read transaction opens with
// i_txn_write low and goes straight to data, so the pointer from the last
// write is reused. That is the only way to read anything but the register
// selected at reset.
//
// Byte order
// Word registers move high byte first. A write commits on the low byte,
// so a transaction cut after the high byte leaves the register untouched.
// A read of the high byte snapshots the whole word, so the low byte that
// follows belongs to the same value even if a sample lands in between.
// Byte registers (flags and configuration) take every byte themselves.
//
// Limitations
// Lowest and highest conversion are plain storage here; tracking of
// extremes belongs to the converter core. Reserved bits are masked on
// write with no error reported. Result bit 15 follows the flags live,
// it is not frozen when a conversion completes.
// No pin is sampled: every input comes from logic on i_clk_sys, so no
// synchroniser stands in front of any of them.
`timescale 1ns/100ps
`include "aprr_map.svh"

module aprr_regs (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire logic i_txn_start,
    input wire logic i_txn_write,
    input wire aprr_pkg::aprr_wbyte_s i_wr,
    input wire logic i_rd_req,
    input wire aprr_pkg::aprr_sample_s i_sample,
    output logic [7:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_conv_start,
    output logic o_auto_mode,
    output logic [1:0] o_flags
);

    // Limit value field of a word register
    // Widened by two bits so sums and differences keep their carry
    function automatic logic [11:0] lim_val(input logic [15:0] w);
        lim_val = {2'h0, w[11:2]};
    endfunction

    // Registers that hold a full 16-bit word
    // Select 0 counts as a word even though writes to it are dropped
    function automatic logic is_word(input logic [2:0] s);
        is_word = (s != `APRR_SEL_FLAGS) && (s != `APRR_SEL_CONFIG);
    endfunction

    // Stored state, plus the combinational next flag value
    aprr_pkg::aprr_phase_e phase_r;
    logic [7:0] ptr_r;
    logic [7:0] cfg_r;
    logic [1:0] flags_r;
    logic [1:0] flags_nxt;
    logic [15:0] low_r;
    logic [15:0] high_r;
    logic [15:0] hyst_r;
    logic [15:0] min_r;
    logic [15:0] max_r;
    logic [9:0] sample_r;
    logic [7:0] wr_hi_r;
    logic [15:0] rd_shadow_r;
    // Decode helpers
    logic [15:0] rd_word;
    logic [15:0] wr_word;
    logic [2:0] cyc_sel;
    logic flags_wr;
    logic [2:0] sel;
    logic hold;
    logic auto_on;
    logic wr_byte;
    logic rd_hi;
    // Flag update terms
    logic [1:0] w1c;
    logic [1:0] set_ev;
    logic [1:0] self_clr;
    logic [11:0] smp;
    logic [11:0] over_rel;
    logic [11:0] under_rel;

    // Pointer bits 7:3 are stored but never decoded
    assign sel = ptr_r[2:0];
    assign hold = cfg_r[`APRR_CFG_HOLD];
    // Any nonzero cycle time means the core converts by itself
    assign cyc_sel = cfg_r[`APRR_CFG_CYC_HI:`APRR_CFG_CYC_LO];
    assign auto_on = cyc_sel != `APRR_AUTO_OFF;
    // A byte in the start cycle is ignored; the engine never sends one there
    assign wr_byte = i_wr.valid && !i_txn_start;
    // Reserved word bits never reach storage
    assign wr_word = {wr_hi_r, i_wr.data} & `APRR_WORD_WMASK;
    assign flags_wr = wr_byte && phase_r == aprr_pkg::AP_HI
        && sel == `APRR_SEL_FLAGS;
    assign rd_hi = i_rd_req && (phase_r != aprr_pkg::AP_LO);

    // Byte position within the transaction
    // PTR expects the pointer byte, HI the first byte of a register and
    // LO the second byte of a word. Reads and writes share one position
    // so a mixed transaction keeps its pairing.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            phase_r <= aprr_pkg::AP_IDLE;
        end else if (i_txn_start) begin
            // Reads begin on data straight away, the pointer stays as is
            phase_r <= i_txn_write ? aprr_pkg::AP_PTR : aprr_pkg::AP_HI;
        end else if (wr_byte || i_rd_req) begin
            case (phase_r)
                aprr_pkg::AP_PTR: begin
                    phase_r <= i_rd_req ? aprr_pkg::AP_LO : aprr_pkg::AP_HI;
                    if (i_rd_req && !is_word(sel)) begin
                        phase_r <= aprr_pkg::AP_HI;
                    end
                end
                aprr_pkg::AP_LO: begin
                    phase_r <= aprr_pkg::AP_HI;
                end
                default: begin
                    // Byte registers repeat on every following byte
                    phase_r <= is_word(sel) ? aprr_pkg::AP_LO
                        : aprr_pkg::AP_HI;
                end
            endcase
        end
    end

    // Pointer register
    // Loaded only by the first byte of a write; a read in that position
    // returns data and leaves the pointer alone.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            ptr_r <= `APRR_PTR_RST;
        end else if (wr_byte && phase_r == aprr_pkg::AP_PTR && !i_rd_req) begin
            ptr_r <= i_wr.data;
        end
    end

    // Data writes to the selected register
    // The high byte is parked in wr_hi_r until its low byte arrives.
    // Flag writes are not handled here: they clear through the flag path
    // so the set-beats-clear ordering lives in one place.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            cfg_r <= `APRR_CFG_RST;
            low_r <= `APRR_LOW_RST;
            high_r <= `APRR_HIGH_RST;
            hyst_r <= `APRR_HYST_RST;
            min_r <= `APRR_MIN_RST;
            max_r <= `APRR_MAX_RST;
            wr_hi_r <= 8'h00;
        end else if (wr_byte && phase_r == aprr_pkg::AP_HI) begin
            wr_hi_r <= i_wr.data;
            if (sel == `APRR_SEL_CONFIG) begin
                cfg_r <= i_wr.data & `APRR_CFG_WMASK;
            end
        end else if (wr_byte && phase_r == aprr_pkg::AP_LO) begin
            // Word commits only on its low byte so no half value is seen
            case (sel)
                `APRR_SEL_LOW: low_r <= wr_word;
                `APRR_SEL_HIGH: high_r <= wr_word;
                `APRR_SEL_HYST: hyst_r <= wr_word;
                `APRR_SEL_MIN: min_r <= wr_word;
                `APRR_SEL_MAX: max_r <= wr_word;
                default: wr_hi_r <= wr_hi_r;
            endcase
        end
    end

    // Latest conversion sample
    // Kept until the core reports the next one; reads never disturb it
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            sample_r <= `APRR_SAMPLE_RST;
        end else if (i_sample.valid) begin
            sample_r <= i_sample.value;
        end
    end

    // Limit checks on each new sample
    // Compared against the incoming value, not sample_r, so the flags
    // change on the same edge as the stored sample. Release points are
    // computed in 12 bits; a hysteresis larger than the high limit makes
    // the over release point negative, so that flag then never
    // self-clears, which is the safe outcome.
    always_comb begin
        smp = {2'h0, i_sample.value};
        over_rel = lim_val(high_r) - lim_val(hyst_r);
        under_rel = lim_val(low_r) + lim_val(hyst_r);
        set_ev = 2'h0;
        self_clr = 2'h0;
        w1c = 2'h0;
        if (i_sample.valid) begin
            set_ev[`APRR_BIT_OVER] = smp > lim_val(high_r);
            set_ev[`APRR_BIT_UNDER] = smp < lim_val(low_r);
            // Signed compare so a large hysteresis cannot wrap
            self_clr[`APRR_BIT_OVER] = !hold
                && ($signed(smp) < $signed(over_rel));
            self_clr[`APRR_BIT_UNDER] = !hold
                && ($signed(smp) > $signed(under_rel));
        end
        if (flags_wr) begin
            w1c = i_wr.data[1:0];
        end
        // Set wins over any clear in the same cycle
        flags_nxt = (flags_r & ~(w1c | self_clr)) | set_ev;
    end

    // Alert flag register
    // Bits 7:2 are not stored at all, so they always read zero
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            flags_r <= `APRR_FLAGS_RST;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // Read value of the selected register
    // Byte registers sit in the low half so one byte path serves both
    always_comb begin
        case (sel)
            `APRR_SEL_RESULT: rd_word = {cfg_r[`APRR_CFG_FLAG_EN] && |flags_r,
                3'h0, sample_r, 2'h0};
            `APRR_SEL_FLAGS: rd_word = {8'h00, 6'h00, flags_r};
            `APRR_SEL_CONFIG: rd_word = {8'h00, cfg_r};
            `APRR_SEL_LOW: rd_word = low_r;
            `APRR_SEL_HIGH: rd_word = high_r;
            `APRR_SEL_HYST: rd_word = hyst_r;
            `APRR_SEL_MIN: rd_word = min_r;
            default: rd_word = max_r;
        endcase
    end

    // Read byte path; low byte comes from the snapshot of the high read
    // Without the snapshot a sample landing between the two bytes could
    // pair an old high half with a new low half.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_rd_data <= 8'h00;
            o_rd_valid <= 1'b0;
            rd_shadow_r <= 16'h0000;
        end else begin
            o_rd_valid <= i_rd_req;
            if (rd_hi) begin
                rd_shadow_r <= rd_word;
                o_rd_data <= is_word(sel) ? rd_word[15:8]
                    : rd_word[7:0];
            end else if (i_rd_req) begin
                o_rd_data <= rd_shadow_r[7:0];
            end
        end
    end

    // Conversion start and status outputs
    // Only the high byte read starts a conversion, so one word read
    // gives one start. o_flags mirrors the next flag value so it moves
    // on the same edge as the register itself.
    always_ff @(posedge i_clk_sys) begin
        if (i_rst) begin
            o_conv_start <= 1'b0;
            o_auto_mode <= 1'b0;
            o_flags <= 2'h0;
        end else begin
            o_conv_start <= rd_hi && !auto_on
                && sel == `APRR_SEL_RESULT;
            o_auto_mode <= auto_on;
            o_flags <= flags_nxt;
        end
    end

endmodule

// [tb/aprr_ctl_model.sv]
// Controller model issuing byte-level register transactions
`timescale 1ns/100ps
module aprr_ctl_model (
    input wire logic i_clk_sys,
    input wire logic [7:0] i_rd_data,
    input wire logic i_rd_valid,
    output logic o_txn_start,
    output logic o_txn_write,
    output aprr_pkg::aprr_wbyte_s o_wr,
    output logic o_rd_req
);
    // Idle at time zero; a dropped byte is inverted so stale data never helps
    initial begin
        o_txn_start = 1'b0;
        o_txn_write = 1'b0;
        o_wr = '0;
        o_rd_req = 1'b0;
    end
    // Each request stands across exactly one sampling edge
    task automatic start(input logic wr);
        @(posedge i_clk_sys);
        #1 o_txn_start = 1'b1;
        o_txn_write = wr;
        @(posedge i_clk_sys);
        #1 o_txn_start = 1'b0;
    endtask
    task automatic wbyte(input logic [7:0] b);
        @(posedge i_clk_sys);
        #1 o_wr = {1'b1, b};
        @(posedge i_clk_sys);
        #1 o_wr = {1'b0, ~b};
    endtask
    // Answer is sampled in the one cycle it stands
    task automatic rbyte(output logic [7:0] b);
        @(posedge i_clk_sys);
        #1 o_rd_req = 1'b1;
        @(posedge i_clk_sys);
        #1 o_rd_req = 1'b0;
        b = i_rd_valid ? i_rd_data : 8'hxx;
    endtask
endmodule

// [tb/aprr_regs_chk.sv]
// Port checks for the register bank
`timescale 1ns/100ps
module aprr_regs_chk (
    input wire logic i_clk_sys,
    input wire logic i_rst,
    input wire aprr_pkg::aprr_wbyte_s i_wr,
    input wire logic i_rd_req,
    input wire aprr_pkg::aprr_sample_s i_sample,
    input wire logic [7:0] o_rd_data,
    input wire logic o_rd_valid,
    input wire logic o_conv_start,
    input wire logic o_auto_mode,
    input wire logic [1:0] o_flags
);
    // One clock domain, so clock and reset are shared
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (i_rst);
    rd_answer_a: assert property (i_rd_req |=> o_rd_valid)
        else $error("read answer missing");
    rd_only_a: assert property (!i_rd_req |=> !o_rd_valid)
        else $error("read answer without request");
    rd_hold_a: assert property (!o_rd_valid && !$past(i_rst) |->
        $stable(o_rd_data)) else $error("read byte moved while idle");
    conv_cause_a: assert property (o_conv_start |->
        o_rd_valid && !o_auto_mode) else $error("stray conversion");
    conv_pulse_a: assert property (o_conv_start |=> !o_conv_start)
        else $error("conversion start too long");
    flag_cause_a: assert property ($changed(o_flags)
        && !$past(i_rst) |-> $past(i_sample.valid || i_wr.valid))
        else $error("flags moved alone");
    over_cause_a: assert property ($rose(o_flags[1]) |->
        $past(i_sample.valid)) else $error("over flag set without sample");
    under_cause_a: assert property ($rose(o_flags[0]) |->
        $past(i_sample.valid)) else $error("under flag set without sample");
    over_clear_a: assert property ($fell(o_flags[1]) && !$past(i_rst) &&
        !$past(i_sample.valid) |-> $past(i_wr.valid && i_wr.data[1]))
        else $error("over flag cleared without a one written");
endmodule

bind aprr_regs aprr_regs_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_wr(i_wr), .i_rd_req(i_rd_req), .i_sample(i_sample),
    .o_rd_data(o_rd_data), .o_rd_valid(o_rd_valid),
    .o_conv_start(o_conv_start), .o_auto_mode(o_auto_mode), .o_flags(o_flags));

// [tb/testbench.sv]
// Self-checking bench for the register bank
`timescale 1ns/100ps
module testbench;
    logic i_clk_sys = 1'b0;
    logic i_rst = 1'b1;
    logic txn_start, txn_write, rd_req, rd_valid, conv_start, auto_mode;
    aprr_pkg::aprr_wbyte_s wr;
    aprr_pkg::aprr_sample_s smp = '0;
    logic [7:0] rd_data;
    logic [1:0] flags;
    int fails = 0;
    int n_compared = 0;
    always #4 i_clk_sys = ~i_clk_sys;
    aprr_regs i_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
        .i_txn_start(txn_start), .i_txn_write(txn_write), .i_wr(wr),
        .i_rd_req(rd_req), .i_sample(smp), .o_rd_data(rd_data),
        .o_rd_valid(rd_valid), .o_conv_start(conv_start),
        .o_auto_mode(auto_mode), .o_flags(flags));
    aprr_ctl_model i_ctl (.i_clk_sys(i_clk_sys), .i_rd_data(rd_data),
        .i_rd_valid(rd_valid), .o_txn_start(txn_start),
        .o_txn_write(txn_write), .o_wr(wr), .o_rd_req(rd_req));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask
    task automatic give_verdict();
        if (fails == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    // Byte registers take one byte, word registers high then low
    task automatic wr2(input logic [2:0] p, input logic [15:0] v);
        i_ctl.start(1'b1);
        i_ctl.wbyte({5'h00, p});
        if (p == 3'h0 || p > 3'h2) i_ctl.wbyte(v[15:8]);
        i_ctl.wbyte(v[7:0]);
    endtask
    // Pointer-only write, then a read transaction that reuses it
    task automatic rd(input logic [2:0] p, output logic [15:0] v,
        output logic c);
        i_ctl.start(1'b1);
        i_ctl.wbyte({5'h00, p});
        i_ctl.start(1'b0);
        i_ctl.rbyte(v[15:8]);
        c = conv_start;
        if (p == 3'h1 || p == 3'h2) v = {8'h00, v[15:8]};
        else i_ctl.rbyte(v[7:0]);
    endtask
    task automatic put(input logic [9:0] s);
        @(posedge i_clk_sys);
        #1 smp = {1'b1, s};
        @(posedge i_clk_sys);
        #1 smp = {1'b0, ~s};
    endtask
    task automatic t_reset();
        logic [15:0] v;
        logic c;
        i_ctl.start(1'b0);
        i_ctl.rbyte(v[15:8]);
        c = conv_start;
        i_ctl.rbyte(v[7:0]);
        chk(v[15:8], 8'h00);
        chk(v[7:0], 8'h00);
        chk({7'h00, c}, 8'h01);
    endtask
    task automatic t_result();
        logic [15:0] v;
        logic c;
        put(10'h2a5);
        wr2(3'h0, 16'hffff);
        rd(3'h0, v, c);
        chk(v[15:8], 8'h0a);
        chk(v[7:0], 8'h94);
        chk({7'h00, c}, 8'h01);
    endtask
    // High field 64, low field 32, margin 4; edges on both sides
    task automatic t_alert();
        logic [9:0] s [8] = '{64, 65, 60, 59, 32, 31, 36, 37};
        logic [1:0] e [8] = '{0, 2, 2, 0, 0, 1, 1, 0};
        logic [15:0] v;
        logic c;
        wr2(3'h4, 16'h0100);
        wr2(3'h3, 16'h0080);
        wr2(3'h5, 16'h0010);
        wr2(3'h2, 16'h0008);
        rd(3'h3, v, c);
        chk(v[15:8], 8'h00);
        chk(v[7:0], 8'h80);
        for (int i = 0; i < 8; i++) begin
            put(s[i]);
            chk({6'h00, flags}, {6'h00, e[i]});
        end
        put(10'h041);
        rd(3'h0, v, c);
        chk(v[15:8], 8'h81);
        wr2(3'h2, 16'h0000);
        rd(3'h0, v, c);
        chk(v[15:8], 8'h01);
    endtask
    task automatic t_hold();
        logic [15:0] v;
        logic c;
        wr2(3'h2, 16'h0010);
        wr2(3'h1, 16'h0000);
        chk({6'h00, flags}, 8'h02);
        put(10'h032);
        rd(3'h1, v, c);
        chk(v[7:0], 8'h02);
        wr2(3'h1, 16'h0002);
        chk({6'h00, flags}, 8'h00);
        wr2(3'h2, 16'h0020);
        rd(3'h0, v, c);
        chk({6'h00, auto_mode, c}, 8'h02);
    endtask
    initial begin
        repeat (12) @(posedge i_clk_sys);
        #1 i_rst = 1'b0;
        t_reset();
        t_result();
        t_alert();
        t_hold();
        give_verdict();
    end
    // Run needs well under a thousand cycles; a hang ends here
    initial begin
        #100000;
        fails++;
        give_verdict();
    end
endmodule
